// ===== dio_filter_pkg.sv
// constants, register map and reset values for the filtered input / edge interrupt block
// assumes a single 100 MHz core clock and a plain one-cycle register port
// Function
// - each input's interrupt is off by default; rising, falling or both selectable
// - filter time defaults to 100 us after reset; software range 0 to 5000000 us
// - per-input polarity, normal by default or inverted, applied before filter and edges
// - hardware filter count accepts 1 to 50,000,000, each count 0.1 us
// - toggling faster than one over twice the filter time is suppressed
package dio_filter_pkg;
    localparam int          NUM_IN          = 12;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          FILT_W          = 26;

    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          FILT_TICK_NS    = 100;
    localparam int          CYCLES_PER_TICK = FILT_TICK_NS / CLK_PERIOD_NS;
    localparam int          PRESC_W         = 4;

    localparam int          FILT_DEFAULT_US = 100;
    localparam int          FILT_TICKS_US   = 1000 / FILT_TICK_NS;
    localparam logic [FILT_W-1:0] FILT_RESET_TICKS = FILT_W'(FILT_DEFAULT_US * FILT_TICKS_US);
    localparam logic [FILT_W-1:0] FILT_MIN      = 26'h0000001;
    localparam logic [FILT_W-1:0] FILT_MAX      = 26'h2FAF080;

    localparam logic [ADDR_W-1:0] OFS_LEVEL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_POLARITY  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RISE_EN   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLEAR     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INT_EN    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FILT_BASE = 8'h40;

    localparam logic [NUM_IN-1:0] POL_RESET     = 12'h000;
    localparam logic [NUM_IN-1:0] EDGE_RESET    = 12'h000;
    localparam logic [NUM_IN-1:0] INT_EN_RESET  = 12'h000;
endpackage

// ===== dio_sync2.sv
// two flip-flop synchroniser for the field inputs
// assumes inputs are asynchronous to the core clock
`timescale 1ns/1ns
`default_nettype none
module dio_sync2
    import dio_filter_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [NUM_IN-1:0] async_i,
    output logic      [NUM_IN-1:0] sync_o
);
    logic [NUM_IN-1:0] meta_q;

    // meta_q is read only by sync_o
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== dio_filter.sv
// hold-time glitch filter and edge detector for one input
// assumes tick_i is a one-cycle strobe every 0.1 us and raw_i is synchronous
`timescale 1ns/1ns
`default_nettype none
module dio_filter
    import dio_filter_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              tick_i,
    input  wire logic              raw_i,
    input  wire logic [FILT_W-1:0] limit_i,
    output logic                   level_o,
    output logic                   rise_o,
    output logic                   fall_o
);
    logic [FILT_W-1:0] cnt_q;
    logic [FILT_W-1:0] cnt_d;
    logic              level_d;
    wire               differs = raw_i != level_o;
    // a limit lowered mid-count must not let the count run past it and wrap
    wire               expired = tick_i && (cnt_q >= limit_i - FILT_W'(1));

    // any return to the old level restarts the count, so short pulses never pass
    always_comb begin
        cnt_d   = cnt_q;
        level_d = level_o;
        if (!differs) begin
            cnt_d = '0;
        end else if (expired) begin
            cnt_d   = '0;
            level_d = raw_i;
        end else if (tick_i) begin
            cnt_d = cnt_q + FILT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q   <= '0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            level_o <= level_d;
            rise_o  <= level_d && !level_o;
            fall_o  <= !level_d && level_o;
        end
    end

    hold_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(level_o) |-> $past(expired))
        else $error("filtered level changed before the hold time ran out");
    new_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(level_o) |-> (level_o == $past(raw_i)) && rise_o == level_o && fall_o == !level_o)
        else $error("filtered level does not follow held raw level");
endmodule
`default_nettype wire

// ===== dio_input_block.sv
// top: input conditioning with polarity, glitch filter, edge interrupts and register port
// assumes a one-cycle read/write strobe master on the core clock; field inputs are asynchronous
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dio_input_block
    import dio_filter_pkg::*;
#(
    parameter logic [FILT_W-1:0] FILT_RESET = FILT_RESET_TICKS
)(
    input  wire logic              CORE_CLK_I,
    input  wire logic              RST_I,
    input  wire logic [NUM_IN-1:0] FIELD_IN_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WR_DATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [DATA_W-1:0] RD_DATA_O,
    output logic      [NUM_IN-1:0] LEVEL_O,
    output logic                   INT_O
);
    logic [NUM_IN-1:0] field_sync;
    logic [NUM_IN-1:0] cond_in;
    logic [NUM_IN-1:0] filt_level;
    logic [NUM_IN-1:0] filt_rise;
    logic [NUM_IN-1:0] filt_fall;
    logic [NUM_IN-1:0] pol_q;
    logic [NUM_IN-1:0] rise_en_q;
    logic [NUM_IN-1:0] fall_en_q;
    logic [NUM_IN-1:0] status_q;
    logic [NUM_IN-1:0] status_d;
    logic [NUM_IN-1:0] int_en_q;
    logic [FILT_W-1:0] filt_time_q [NUM_IN];
    logic [PRESC_W-1:0] presc_q;
    logic [DATA_W-1:0] rd_mux;
    logic [FILT_W-1:0] filt_rd;

    dio_sync2 u_sync (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RST_I),
        .async_i (FIELD_IN_I),
        .sync_o  (field_sync)
    );

    // shared 0.1 us time base; the hold window may start anywhere inside a tick
    wire tick = presc_q == PRESC_W'(CYCLES_PER_TICK - 1);

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            presc_q <= '0;
        end else begin
            presc_q <= tick ? '0 : presc_q + PRESC_W'(1);
        end
    end

    // inverting ahead of the filter keeps edges and level in the sensed sense
    assign cond_in = field_sync ^ pol_q;

    // write decode
    wire wr_pol    = WR_I && ADDR_I == OFS_POLARITY;
    wire wr_rise   = WR_I && ADDR_I == OFS_RISE_EN;
    wire wr_fall   = WR_I && ADDR_I == OFS_FALL_EN;
    wire wr_clear  = WR_I && ADDR_I == OFS_CLEAR;
    wire wr_int_en = WR_I && ADDR_I == OFS_INT_EN;
    wire [ADDR_W-1:0] filt_ofs = ADDR_I - OFS_FILT_BASE;
    wire [ADDR_W-3:0] filt_idx = filt_ofs[ADDR_W-1:2];
    wire filt_hit  = ADDR_I >= OFS_FILT_BASE && filt_ofs[1:0] == 2'b00 && filt_idx < (ADDR_W-2)'(NUM_IN);

    // out-of-range counts are pinned to the nearest legal value
    wire [FILT_W-1:0] wr_filt_val = (WR_DATA_I[DATA_W-1:FILT_W] != '0 || WR_DATA_I[FILT_W-1:0] > FILT_MAX) ?
                                    FILT_MAX :
                                    (WR_DATA_I[FILT_W-1:0] < FILT_MIN) ? FILT_MIN : WR_DATA_I[FILT_W-1:0];

    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++) begin : g_in
            always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    filt_time_q[g] <= FILT_RESET;
                end else if (WR_I && filt_hit && filt_idx == (ADDR_W-2)'(g)) begin
                    filt_time_q[g] <= wr_filt_val;
                end
            end

            dio_filter u_filt (
                .clk_i   (CORE_CLK_I),
                .rst_i   (RST_I),
                .tick_i  (tick),
                .raw_i   (cond_in[g]),
                .limit_i (filt_time_q[g]),
                .level_o (filt_level[g]),
                .rise_o  (filt_rise[g]),
                .fall_o  (filt_fall[g])
            );
        end
    endgenerate

    // edge events only count for the selected sense; none selected means disabled
    wire [NUM_IN-1:0] edge_evt = (filt_rise & rise_en_q) | (filt_fall & fall_en_q);
    // a new event wins over a clear in the same cycle
    assign status_d = (status_q & ~(wr_clear ? WR_DATA_I[NUM_IN-1:0] : '0)) | edge_evt;

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pol_q     <= POL_RESET;
            rise_en_q <= EDGE_RESET;
            fall_en_q <= EDGE_RESET;
            int_en_q  <= INT_EN_RESET;
            status_q  <= '0;
        end else begin
            if (wr_pol) pol_q <= WR_DATA_I[NUM_IN-1:0];
            if (wr_rise) rise_en_q <= WR_DATA_I[NUM_IN-1:0];
            if (wr_fall) fall_en_q <= WR_DATA_I[NUM_IN-1:0];
            if (wr_int_en) int_en_q <= WR_DATA_I[NUM_IN-1:0];
            status_q <= status_d;
        end
    end

    assign INT_O   = |(status_q & int_en_q);
    assign LEVEL_O = filt_level;

    // read decode; unmapped and write-only addresses read zero
    assign filt_rd = filt_time_q[filt_idx < (ADDR_W-2)'(NUM_IN) ? filt_idx[3:0] : 4'h0];
    assign rd_mux  = (ADDR_I == OFS_LEVEL)    ? {{(DATA_W-NUM_IN){1'b0}}, filt_level} :
                     (ADDR_I == OFS_POLARITY) ? {{(DATA_W-NUM_IN){1'b0}}, pol_q} :
                     (ADDR_I == OFS_RISE_EN)  ? {{(DATA_W-NUM_IN){1'b0}}, rise_en_q} :
                     (ADDR_I == OFS_FALL_EN)  ? {{(DATA_W-NUM_IN){1'b0}}, fall_en_q} :
                     (ADDR_I == OFS_STATUS)   ? {{(DATA_W-NUM_IN){1'b0}}, status_q} :
                     (ADDR_I == OFS_INT_EN)   ? {{(DATA_W-NUM_IN){1'b0}}, int_en_q} :
                     filt_hit                 ? {{(DATA_W-FILT_W){1'b0}}, filt_rd} :
                     '0;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RD_DATA_O <= '0;
        end else begin
            RD_DATA_O <= RD_I ? rd_mux : '0;
        end
    end

    rise_sets_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        filt_rise[0] && rise_en_q[0] |=>
            status_q[0] && (INT_O == (int_en_q[0] | (|(status_q[NUM_IN-1:1] & int_en_q[NUM_IN-1:1])))))
        else $error("enabled rising edge did not set status");
    disabled_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !rise_en_q[0] && !fall_en_q[0] && !status_q[0] |=> !status_q[0])
        else $error("status set on an input with edges disabled");
    filt_default_a: assert property (@(posedge CORE_CLK_I)
        $fell(RST_I) |-> filt_time_q[0] == FILT_RESET && !rise_en_q[0] && !fall_en_q[0])
        else $error("filter time or edge select wrong after reset");
    polarity_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        wr_pol |=> cond_in == (field_sync ^ $past(WR_DATA_I[NUM_IN-1:0])))
        else $error("polarity not applied to conditioned input");
    filt_range_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        filt_time_q[0] >= FILT_MIN && filt_time_q[0] <= FILT_MAX)
        else $error("filter count out of range");
    clear_order_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        wr_clear && WR_DATA_I[0] && !edge_evt[0] |=> !status_q[0])
        else $error("clear did not drop status");
    set_wins_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        |edge_evt |=> (status_q & $past(edge_evt)) == $past(edge_evt))
        else $error("edge event lost against a clear");

    int_seen_c:   cover property (@(posedge CORE_CLK_I) disable iff (RST_I) $rose(INT_O));
    fall_evt_c:   cover property (@(posedge CORE_CLK_I) disable iff (RST_I) filt_fall[0] && fall_en_q[0]);
    inverted_c:   cover property (@(posedge CORE_CLK_I) disable iff (RST_I) pol_q[0] && $rose(filt_level[0]));
    clash_c:      cover property (@(posedge CORE_CLK_I) disable iff (RST_I) wr_clear && WR_DATA_I[0] && edge_evt[0]);
endmodule
`default_nettype wire

// ===== field_sensor_model.sv
// field sensor model: drives the raw input points of the conditioning block
// assumes the bench core clock; levels change only right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module field_sensor_model
    import dio_filter_pkg::*;
(
    input  wire logic              clk_i,
    output logic      [NUM_IN-1:0] field_o
);
    initial field_o = '0;

    task automatic set_level(input int idx, input logic val);
        @(posedge clk_i);
        field_o[idx] <= val;
    endtask

    // a pulse longer than the filter time is meant to pass, a shorter one to vanish
    task automatic pulse(input int idx, input int len);
        set_level(idx, ~field_o[idx]);
        repeat (len) @(posedge clk_i);
        field_o[idx] <= ~field_o[idx];
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the filtered input / edge interrupt block
// assumes the design's one-cycle register port and a reduced filter reset value
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dio_filter_pkg::*;
    localparam logic [FILT_W-1:0] FR = 26'h0000002;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic [NUM_IN-1:0] field;
    logic [NUM_IN-1:0] level;
    logic              irq;
    logic [DATA_W-1:0] d;
    int                error_cnt;
    int                tests_run;
    logic [ADDR_W-1:0] zero_regs [7] = '{OFS_POLARITY, OFS_RISE_EN, OFS_FALL_EN, OFS_INT_EN,
                                         OFS_STATUS, OFS_CLEAR, 8'h30};

    field_sensor_model field_sensor_model_inst (.clk_i(clk), .field_o(field));

    dio_input_block #(.FILT_RESET(FR)) dio_input_block_inst (
        .CORE_CLK_I(clk), .RST_I(rst), .FIELD_IN_I(field), .ADDR_I(addr), .WR_DATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .LEVEL_O(level), .INT_O(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        error_cnt = 0; tests_run = 0;
        rst = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // reset values, write-only and unmapped places read zero
        foreach (zero_regs[i]) begin
            rd_reg(zero_regs[i]);
            chk("reset reg", d, 32'h0000_0000);
        end
        rd_reg(8'h6C);
        chk("filter reset", d, {6'h00, FR});
        // filter count clamps to the hardware range
        wr_reg(8'h44, 32'h0000_0000);
        rd_reg(8'h44);
        chk("filter min", d, {6'h00, FILT_MIN});
        wr_reg(8'h44, 32'h0300_0000);
        rd_reg(8'h44);
        chk("filter max", d, {6'h00, FILT_MAX});
        wr_reg(8'h44, {6'h00, FR});
        // three ticks of 10 cycles: early sample must still be low
        wr_reg(OFS_FILT_BASE, 32'h0000_0003);
        cyc(40);
        field_sensor_model_inst.set_level(0, 1'b1);
        cyc(20);
        chk("level early", {20'h00000, level}, 32'h0000_0000);
        cyc(15);
        chk("level held", {20'h00000, level}, 32'h0000_0001);
        field_sensor_model_inst.pulse(0, 15);
        cyc(40);
        chk("glitch low", {20'h00000, level}, 32'h0000_0001);
        // a low pulse well beyond the filter time passes and ends again
        field_sensor_model_inst.pulse(0, 60);
        cyc(5);
        chk("pulse passed", {20'h00000, level}, 32'h0000_0000);
        cyc(40);
        chk("pulse ended", {20'h00000, level}, 32'h0000_0001);
        // inverted sense on input 1 with its pin low
        wr_reg(OFS_POLARITY, 32'h0000_0002);
        cyc(40);
        rd_reg(OFS_LEVEL);
        chk("level inverted", d, 32'h0000_0003);
        cyc(1);
        chk("read data drops", rdata, 32'h0000_0000);
        wr_reg(OFS_POLARITY, 32'h0000_0000);
        cyc(40);
        chk("level normal", {20'h00000, level}, 32'h0000_0001);
        // edge modes on input 2: off, rise, fall, both
        wr_reg(OFS_INT_EN, 32'h0000_0004);
        for (int m = 0; m < 4; m++) begin
            wr_reg(OFS_RISE_EN, m[0] ? 32'h0000_0004 : 32'h0000_0000);
            wr_reg(OFS_FALL_EN, m[1] ? 32'h0000_0004 : 32'h0000_0000);
            wr_reg(OFS_CLEAR, 32'h0000_0FFF);
            field_sensor_model_inst.set_level(2, 1'b1);
            cyc(40);
            rd_reg(OFS_STATUS);
            chk("status rise", d, m[0] ? 32'h0000_0004 : 32'h0000_0000);
            chk("irq rise", {31'h00000000, irq}, {31'h00000000, m[0]});
            wr_reg(OFS_CLEAR, 32'h0000_0004);
            field_sensor_model_inst.set_level(2, 1'b0);
            cyc(40);
            rd_reg(OFS_STATUS);
            chk("status fall", d, m[1] ? 32'h0000_0004 : 32'h0000_0000);
            chk("irq fall", {31'h00000000, irq}, {31'h00000000, m[1]});
        end
        // masking keeps the sticky bit but drops the line; clearing empties it
        wr_reg(OFS_INT_EN, 32'h0000_0000);
        cyc(1);
        chk("irq masked", {31'h00000000, irq}, 32'h0000_0000);
        rd_reg(OFS_STATUS);
        chk("status sticky", d, 32'h0000_0004);
        wr_reg(OFS_CLEAR, 32'h0000_0004);
        rd_reg(OFS_STATUS);
        chk("status cleared", d, 32'h0000_0000);
        wrap_up();
    end
endmodule
`default_nettype wire
